/* testbench.sv */
// Self-checking bench for the waveform playback block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic stream_mode = 1'b1;
	logic start_trigger = 1'b0;
	logic stop = 1'b0;
	logic sequence_trigger_zero = 1'b0;
	logic script_wr = 1'b0;
	logic [wpds_pkg::SAW-1:0] script_wr_addr = 4'h0;
	wpds_pkg::wpds_instr_t script_wr_instr = '0;
	logic wr_restart;
	logic wr_valid;
	logic wr_ready;
	logic [15:0] wr_data;
	logic [15:0] sample_out;
	logic [6:0] buf_words = 7'h08;
	logic [6:0] block_words = 7'h04;
	wpds_pkg::wpds_dm_cfg_t dm_cfg [wpds_pkg::MARKERS];
	logic err_clear = 1'b0;
	logic sample_valid;
	logic script_marker;
	logic busy;
	logic done;
	logic [3:0] data_marker;
	logic [6:0] space_avail;
	wpds_pkg::wpds_err_t errors;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	int t0 = 0;
	int nmark = 0;
	int ndone = 0;
	int wp = 0;
	bit first = 1'b0;
	logic [31:0] lfsr = 32'hcd76e859;
	logic [15:0] mem [64];
	logic [15:0] exp_q [$];
	logic [15:0] e;

	always #2.5 clk = ~clk;

	wpds_top i_dut (.clk(clk), .resetn(resetn), .stream_mode(stream_mode),
		.start_trigger(start_trigger), .stop(stop), .sequence_trigger_zero(sequence_trigger_zero),
		.script_wr(script_wr), .script_wr_addr(script_wr_addr), .script_wr_instr(script_wr_instr),
		.wr_restart(wr_restart), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.buf_words(buf_words), .block_words(block_words), .dm_cfg(dm_cfg), .err_clear(err_clear),
		.sample_out(sample_out), .sample_valid(sample_valid), .data_marker(data_marker),
		.script_marker(script_marker), .busy(busy), .done(done), .space_avail(space_avail),
		.errors(errors));
	wpds_host_model i_host (.clk(clk), .wr_ready(wr_ready), .wr_valid(wr_valid),
		.wr_data(wr_data), .wr_restart(wr_restart));

	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h00000000);
	endfunction
	function automatic logic [3:0] dm_exp(input logic [15:0] s);
		for (int i = 0; i < wpds_pkg::MARKERS; i++) begin
			dm_exp[i] = dm_cfg[i].enable & (s[dm_cfg[i].bit_sel] ^ dm_cfg[i].invert);
		end
	endfunction
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
		checks++;
		if (seen !== expv) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, expv, seen);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic set_cfg();
		for (int i = 0; i < wpds_pkg::MARKERS; i++) begin
			lfsr = lfsr_next(lfsr);
			dm_cfg[i] = '{lfsr[3:0], lfsr[4], (i != 3) | lfsr[5]};
		end
	endtask
	task automatic send(input int n, input bit to_q);
		logic [15:0] d;
		for (int k = 0; k < n; k++) begin
			lfsr = lfsr_next(lfsr);
			d = lfsr[15:0];
			if (to_q) exp_q.push_back(d);
			else mem[wp++] = d;
			i_host.push(d);
		end
		i_host.idle();
	endtask
	task automatic put(input logic [3:0] slot, input wpds_pkg::wpds_op_t op,
		input logic [5:0] a, input logic [5:0] l, input logic [7:0] c, input logic me);
		@(negedge clk);
		script_wr = 1'b1;
		script_wr_addr = slot;
		script_wr_instr = '{op, a, l, c, me, 6'h00};
		@(negedge clk);
		script_wr = 1'b0;
	endtask
	task automatic fire_start();
		@(negedge clk);
		start_trigger = 1'b1;
		t0 = cyc;
		first = 1'b1;
		repeat (4) @(negedge clk);
		start_trigger = 1'b0;
	endtask
	task automatic clear_err();
		@(negedge clk);
		err_clear = 1'b1;
		@(negedge clk);
		err_clear = 1'b0;
		check("errors cleared", errors, 0);
	endtask
	task automatic wait_until(input bit for_space);
		int n;
		n = 0;
		while ((for_space ? space_avail < 4 : busy !== 1'b0) && n < 2000) begin
			@(negedge clk);
			n++;
		end
		check("wait bound", n < 2000, 1);
	endtask

	// Results are compared where they are settled, half a cycle after launch
	always @(negedge clk) begin
		if (resetn === 1'b1 && sample_valid === 1'b1) begin
			if (first) begin
				check("start latency", (cyc - t0) >= wpds_pkg::START_LAT_CYC, 1);
				first = 1'b0;
			end
			if (exp_q.size() == 0) begin
				check("unexpected sample", 0, 1);
			end else begin
				e = exp_q.pop_front();
				check("sample_out", sample_out, e);
				check("data_marker", data_marker, dm_exp(e));
			end
		end
		if (script_marker === 1'b1) begin
			nmark++;
			check("marker sample", sample_out, mem[0]);
		end
		if (done === 1'b1) ndone++;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			print_verdict();
		end
	end

	initial begin
		set_cfg();
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		check("busy rst", busy, 0);
		check("wr_ready rst", wr_ready, 1);
		check("errors rst", errors, 0);
		check("space rst", space_avail, 8);
		buf_words = 7'h0c;
		block_words = 7'h05;
		fire_start();
		repeat (10) @(negedge clk);
		check("len_bad", errors.len_bad, 1);
		check("busy refused", busy, 0);
		clear_err();
		buf_words = 7'h08;
		block_words = 7'h04;
		// Script: wait, repeat with marker, two-entry loop, counts 0 and 1
		stream_mode = 1'b0;
		i_host.restart();
		set_cfg();
		send(8, 1'b0);
		put(4'h0, wpds_pkg::WPDS_OP_WAIT, 6'h00, 6'h00, 8'h00, 1'b0);
		put(4'h1, wpds_pkg::WPDS_OP_GEN, 6'h00, 6'h03, 8'h02, 1'b1);
		put(4'h2, wpds_pkg::WPDS_OP_LOOP, 6'h00, 6'h00, 8'h02, 1'b0);
		put(4'h3, wpds_pkg::WPDS_OP_GEN, 6'h04, 6'h01, 8'h00, 1'b0);
		put(4'h4, wpds_pkg::WPDS_OP_GEN, 6'h06, 6'h01, 8'h01, 1'b0);
		put(4'h5, wpds_pkg::WPDS_OP_ENDLOOP, 6'h00, 6'h00, 8'h00, 1'b0);
		put(4'h6, wpds_pkg::WPDS_OP_END, 6'h00, 6'h00, 8'h00, 1'b0);
		for (int k = 0; k < 16; k++) begin
			exp_q.push_back(mem[k < 8 ? k % 4 : 4 + k % 4]);
		end
		fire_start();
		repeat (100) @(negedge clk);
		check("wait holds", exp_q.size(), 16);
		check("busy in wait", busy, 1);
		sequence_trigger_zero = 1'b1;
		wait_until(1'b0);
		repeat (2) @(negedge clk);
		sequence_trigger_zero = 1'b0;
		check("script left", exp_q.size(), 0);
		check("script markers", nmark, 2);
		check("script done", ndone, 1);
		// Stream: preload, refill in blocks, 24 words through an 8-word ring
		stream_mode = 1'b1;
		i_host.restart();
		set_cfg();
		send(16, 1'b1);
		fire_start();
		for (int b = 0; b < 2; b++) begin
			wait_until(1'b1);
			send(4, 1'b1);
		end
		repeat (40) @(negedge clk);
		check("stream left", exp_q.size(), 0);
		check("no overwrite", errors.overwrite, 0);
		check("underrun", errors.underrun, 1);
		stop = 1'b1;
		repeat (4) @(negedge clk);
		stop = 1'b0;
		check("stop idle", busy, 0);
		check("stop done", ndone, 2);
		clear_err();
		// Buffer and FIFO both full, then one more push must be refused
		i_host.restart();
		send(24, 1'b0);
		i_host.shove(16'h5a5a, 3);
		check("refused", wr_ready, 0);
		check("overwrite", errors.overwrite, 1);
		clear_err();
		print_verdict();
	end
endmodule
`default_nettype wire

/* wpds_fifo.sv */
// Shared constants and types for the waveform playback block, plus its input FIFO
`timescale 1ns/100ps
`default_nettype none

package wpds_pkg;
	localparam int SAMPLE_W = 16;
	localparam int MARKERS = 4;
	localparam int BITSEL_W = 4;
	localparam int AW = 6;
	localparam int SAW = 4;
	localparam int CNT_W = 8;
	localparam int FIFO_DEPTH = 16;
	// Start latency, in Sample clock periods; clk is the Sample clock
	localparam int START_LAT_PERIODS = 44;
	localparam int START_LAT_CYC = START_LAT_PERIODS * 1;
	localparam logic [SAW-1:0] PC_RESET = 4'h0;

	typedef enum logic [2:0] {
		WPDS_OP_END = 3'h0,
		WPDS_OP_GEN = 3'h1,
		WPDS_OP_LOOP = 3'h2,
		WPDS_OP_ENDLOOP = 3'h3,
		WPDS_OP_WAIT = 3'h4
	} wpds_op_t;

	typedef enum logic [2:0] {
		WPDS_S_IDLE = 3'h0,
		WPDS_S_LAT = 3'h1,
		WPDS_S_FETCH = 3'h2,
		WPDS_S_PLAY = 3'h3,
		WPDS_S_WAIT = 3'h4
	} wpds_state_t;

	typedef struct packed {
		wpds_op_t op;
		logic [AW-1:0] addr;
		logic [AW-1:0] len_m1;
		logic [CNT_W-1:0] count;
		logic mark_en;
		logic [AW-1:0] mark_pos;
	} wpds_instr_t;

	typedef struct packed {
		logic [BITSEL_W-1:0] bit_sel;
		logic invert;
		logic enable;
	} wpds_dm_cfg_t;

	typedef struct packed {
		logic len_bad;
		logic overwrite;
		logic underrun;
	} wpds_err_t;
endpackage

module wpds_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0] head;
	logic [PW-1:0] tail;
	logic [PW:0] fill;
	logic push;
	logic pop;

	assign in_ready = (fill != DEPTH[PW:0]);
	assign out_valid = (fill != '0);
	assign out_data = store[head];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			store[tail] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			head <= '0;
			tail <= '0;
			fill <= '0;
		end else begin
			if (push) begin
				tail <= (tail == PW'(DEPTH - 1)) ? '0 : tail + 1'b1;
			end
			if (pop) begin
				head <= (head == PW'(DEPTH - 1)) ? '0 : head + 1'b1;
			end
			fill <= fill + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
		end
	end
endmodule

`default_nettype wire

/* wpds_host_model.sv */
// Host-side model that writes waveform samples into the playback block
`timescale 1ns/100ps
`default_nettype none
module wpds_host_model (
	input wire logic clk,
	input wire logic wr_ready,
	output logic wr_valid,
	output logic [wpds_pkg::SAMPLE_W-1:0] wr_data,
	output logic wr_restart
);
	initial begin
		wr_valid = 1'b0;
		wr_data = 16'h0000;
		wr_restart = 1'b0;
	end
	// Words go out in order, one after the other; valid stays up between words
	task automatic push(input logic [wpds_pkg::SAMPLE_W-1:0] d);
		@(negedge clk);
		wr_valid = 1'b1;
		wr_data = d;
		while (wr_ready !== 1'b1) begin
			@(negedge clk);
		end
		@(posedge clk);
	endtask
	// Released data shows the inverse so a stale word can never pass for fresh
	task automatic idle();
		@(negedge clk);
		wr_valid = 1'b0;
		wr_data = ~wr_data;
	endtask
	task automatic restart();
		@(negedge clk);
		wr_restart = 1'b1;
		@(negedge clk);
		wr_restart = 1'b0;
	endtask
	// Pushes without waiting for ready, only to provoke a refusal
	task automatic shove(input logic [wpds_pkg::SAMPLE_W-1:0] d, input int n);
		@(negedge clk);
		wr_valid = 1'b1;
		wr_data = d;
		repeat (n) @(negedge clk);
		wr_valid = 1'b0;
		wr_data = ~d;
	endtask
endmodule
`default_nettype wire

/* wpds_top.sv */
// Waveform playback: data markers, script sequencer and streaming buffer
`timescale 1ns/100ps
`default_nettype none

module wpds_top #(
	parameter int AW = wpds_pkg::AW,
	parameter int FIFO_DEPTH = wpds_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic stream_mode,
	input wire logic start_trigger,
	input wire logic stop,
	input wire logic sequence_trigger_zero,
	input wire logic script_wr,
	input wire logic [wpds_pkg::SAW-1:0] script_wr_addr,
	input wire wpds_pkg::wpds_instr_t script_wr_instr,
	input wire logic wr_restart,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [wpds_pkg::SAMPLE_W-1:0] wr_data,
	input wire logic [AW:0] buf_words,
	input wire logic [AW:0] block_words,
	input wire wpds_pkg::wpds_dm_cfg_t dm_cfg [wpds_pkg::MARKERS],
	input wire logic err_clear,
	output logic [wpds_pkg::SAMPLE_W-1:0] sample_out,
	output logic sample_valid,
	output logic [wpds_pkg::MARKERS-1:0] data_marker,
	output logic script_marker,
	output logic busy,
	output logic done,
	output logic [AW:0] space_avail,
	output wpds_pkg::wpds_err_t errors
);
	localparam int SW = wpds_pkg::SAMPLE_W;
	localparam int DEPTH = 2 ** AW;

	logic [SW-1:0] mem [DEPTH];
	wpds_pkg::wpds_instr_t script [2 ** wpds_pkg::SAW];
	wpds_pkg::wpds_state_t state;
	wpds_pkg::wpds_instr_t cur;
	logic [2:0] start_sync;
	logic [1:0] trig_sync;
	logic start_edge;
	logic [6:0] lat_cnt;
	logic [wpds_pkg::SAW-1:0] pc;
	logic [wpds_pkg::SAW-1:0] loop_pc;
	logic [wpds_pkg::CNT_W-1:0] loop_cnt;
	logic [wpds_pkg::CNT_W-1:0] reps;
	logic [AW-1:0] rd_ptr;
	logic [AW-1:0] offset;
	logic [AW-1:0] wr_ptr;
	logic [AW:0] level;
	logic [SW-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_ready;
	logic wr_fire;
	logic play_fire;
	logic len_bad;
	logic wave_end;
	logic buf_full;
	logic [SW-1:0] word;

	// Block size checked against the reserved buffer; a zero block is never legal
	assign len_bad = (block_words == '0) || ((buf_words % block_words) != '0);
	assign buf_full = stream_mode && (level >= buf_words);
	assign fifo_ready = !buf_full;
	assign wr_fire = fifo_valid && fifo_ready;
	assign play_fire = (state == wpds_pkg::WPDS_S_PLAY) && (!stream_mode || level != '0);
	assign wave_end = (offset == cur.len_m1);
	assign start_edge = start_sync[1] && !start_sync[2];
	assign word = mem[rd_ptr];
	assign space_avail = buf_full ? '0 : buf_words - level;

	wpds_fifo #(
		.WIDTH(SW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data(wr_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_data)
	);

	// Both trigger pins pass two flops, stop is used unsynchronised; the third stage only feeds edge detection
	always_ff @(posedge clk) begin
		if (!resetn) begin
			start_sync <= '0;
			trig_sync <= '0;
		end else begin
			start_sync <= {start_sync[1:0], start_trigger};
			trig_sync <= {trig_sync[0], sequence_trigger_zero};
		end
	end

	always_ff @(posedge clk) begin
		if (script_wr) begin
			script[script_wr_addr] <= script_wr_instr;
		end
		if (wr_fire) begin
			mem[wr_ptr] <= fifo_data;
		end
	end

	// Writes append; in streaming the pointer wraps at the reserved size
	always_ff @(posedge clk) begin
		if (!resetn || wr_restart) begin
			wr_ptr <= '0;
		end else if (wr_fire) begin
			if (stream_mode && ({1'b0, wr_ptr} == buf_words - 1'b1)) begin
				wr_ptr <= '0;
			end else begin
				wr_ptr <= wr_ptr + 1'b1;
			end
		end
	end

	// Unplayed words held in the stream buffer
	always_ff @(posedge clk) begin
		if (!resetn || wr_restart || !stream_mode) begin
			level <= '0;
		end else begin
			level <= level + {{AW{1'b0}}, wr_fire} - {{AW{1'b0}}, play_fire};
		end
	end

	// Errors stay set until cleared; a new event in the clear cycle wins
	always_ff @(posedge clk) begin
		if (!resetn) begin
			errors <= '0;
		end else begin
			if (err_clear) begin
				errors <= '0;
			end
			if (state == wpds_pkg::WPDS_S_PLAY && stream_mode && level == '0) begin
				errors.underrun <= 1'b1;
			end
			if (wr_valid && !wr_ready && buf_full) begin
				errors.overwrite <= 1'b1;
			end
			if (start_edge && state == wpds_pkg::WPDS_S_IDLE && stream_mode && len_bad) begin
				errors.len_bad <= 1'b1;
			end
		end
	end

	// Sequencer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= wpds_pkg::WPDS_S_IDLE;
			lat_cnt <= '0;
			pc <= wpds_pkg::PC_RESET;
			loop_pc <= wpds_pkg::PC_RESET;
			loop_cnt <= '0;
			reps <= '0;
			cur <= '0;
			rd_ptr <= '0;
			offset <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (state)
				wpds_pkg::WPDS_S_IDLE: begin
					pc <= wpds_pkg::PC_RESET;
					rd_ptr <= '0;
					if (start_edge && !(stream_mode && len_bad)) begin
						lat_cnt <= 7'(wpds_pkg::START_LAT_CYC - 1);
						state <= wpds_pkg::WPDS_S_LAT;
					end
				end
				wpds_pkg::WPDS_S_LAT: begin
					// Counting here keeps output behind the trigger by the full latency
					lat_cnt <= lat_cnt - 1'b1;
					if (lat_cnt == '0) begin
						state <= stream_mode ? wpds_pkg::WPDS_S_PLAY : wpds_pkg::WPDS_S_FETCH;
					end
				end
				wpds_pkg::WPDS_S_FETCH: begin
					cur <= script[pc];
					unique case (script[pc].op)
						wpds_pkg::WPDS_OP_GEN: begin
							rd_ptr <= script[pc].addr;
							offset <= '0;
							reps <= (script[pc].count == '0) ? '0 : script[pc].count - 1'b1;
							state <= wpds_pkg::WPDS_S_PLAY;
						end
						wpds_pkg::WPDS_OP_LOOP: begin
							// One loop level only; a nested loop replaces the outer one
							loop_pc <= pc + 1'b1;
							loop_cnt <= (script[pc].count == '0) ? '0 : script[pc].count - 1'b1;
							pc <= pc + 1'b1;
						end
						wpds_pkg::WPDS_OP_ENDLOOP: begin
							if (loop_cnt != '0) begin
								loop_cnt <= loop_cnt - 1'b1;
								pc <= loop_pc;
							end else begin
								pc <= pc + 1'b1;
							end
						end
						wpds_pkg::WPDS_OP_WAIT: begin
							state <= wpds_pkg::WPDS_S_WAIT;
						end
						default: begin
							done <= 1'b1;
							state <= wpds_pkg::WPDS_S_IDLE;
						end
					endcase
				end
				wpds_pkg::WPDS_S_WAIT: begin
					if (trig_sync[1]) begin
						pc <= pc + 1'b1;
						state <= wpds_pkg::WPDS_S_FETCH;
					end
				end
				wpds_pkg::WPDS_S_PLAY: begin
					if (stream_mode) begin
						if (stop) begin
							done <= 1'b1;
							state <= wpds_pkg::WPDS_S_IDLE;
						end else if (play_fire) begin
							if ({1'b0, rd_ptr} == buf_words - 1'b1) begin
								rd_ptr <= '0;
							end else begin
								rd_ptr <= rd_ptr + 1'b1;
							end
						end
					end else if (wave_end) begin
						if (reps != '0) begin
							reps <= reps - 1'b1;
							rd_ptr <= cur.addr;
							offset <= '0;
						end else begin
							pc <= pc + 1'b1;
							state <= wpds_pkg::WPDS_S_FETCH;
						end
					end else begin
						rd_ptr <= rd_ptr + 1'b1;
						offset <= offset + 1'b1;
					end
				end
				default: begin
					state <= wpds_pkg::WPDS_S_IDLE;
				end
			endcase
		end
	end

	assign busy = (state != wpds_pkg::WPDS_S_IDLE);

	// Sample and markers share one register stage so they leave together
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sample_out <= '0;
			sample_valid <= 1'b0;
			script_marker <= 1'b0;
		end else begin
			sample_valid <= play_fire;
			if (play_fire) begin
				sample_out <= word;
			end
			script_marker <= play_fire && !stream_mode && cur.mark_en
				&& (offset == cur.mark_pos);
		end
	end

	for (genvar i = 0; i < wpds_pkg::MARKERS; i++) begin : g_dm
		always_ff @(posedge clk) begin
			if (!resetn) begin
				data_marker[i] <= 1'b0;
			end else if (play_fire) begin
				data_marker[i] <= dm_cfg[i].enable
					&& (word[dm_cfg[i].bit_sel] ^ dm_cfg[i].invert);
			end
		end

		AST_DM_LEVEL: assert property (@(posedge clk) disable iff (!resetn)
			$rose(sample_valid) || ($past(sample_valid) && sample_valid) |->
			data_marker[i] == ($past(dm_cfg[i].enable)
				&& (sample_out[$past(dm_cfg[i].bit_sel)] ^ $past(dm_cfg[i].invert))))
			else $error("data marker level does not follow its sample bit");

		AST_DM_ALIGN: assert property (@(posedge clk) disable iff (!resetn)
			$changed(data_marker[i]) |-> sample_valid)
			else $error("data marker moved without a sample");
	end

	logic [7:0] since_start;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			since_start <= '0;
		end else if (start_edge && state == wpds_pkg::WPDS_S_IDLE) begin
			since_start <= 8'h01;
		end else if (since_start != 8'hff) begin
			since_start <= since_start + 1'b1;
		end
	end

	AST_START_LAT: assert property (@(posedge clk) disable iff (!resetn)
		$rose(sample_valid) |-> since_start >= wpds_pkg::START_LAT_CYC)
		else $error("output began too soon after start");

	AST_WR_CONTIG: assert property (@(posedge clk) disable iff (!resetn)
		wr_fire && !wr_restart && !stream_mode |=> wr_ptr == $past(wr_ptr) + 1'b1)
		else $error("host block not appended");

	AST_CIRC: assert property (@(posedge clk) disable iff (!resetn)
		play_fire && stream_mode && !stop && ({1'b0, rd_ptr} == buf_words - 1'b1)
		|=> rd_ptr == '0)
		else $error("stream buffer did not wrap");

	AST_LEN_REJECT: assert property (@(posedge clk) disable iff (!resetn || err_clear)
		start_edge && state == wpds_pkg::WPDS_S_IDLE && stream_mode && len_bad
		|=> state == wpds_pkg::WPDS_S_IDLE && errors.len_bad)
		else $error("bad block length accepted");

	AST_UNDERRUN: assert property (@(posedge clk) disable iff (!resetn)
		state == wpds_pkg::WPDS_S_PLAY && stream_mode && level == '0 |=> errors.underrun)
		else $error("underrun not flagged");

	AST_WAIT: assert property (@(posedge clk) disable iff (!resetn)
		state == wpds_pkg::WPDS_S_WAIT && !trig_sync[1] |=> state == wpds_pkg::WPDS_S_WAIT)
		else $error("wait left without trigger");

	AST_REPEAT: assert property (@(posedge clk) disable iff (!resetn)
		state == wpds_pkg::WPDS_S_PLAY && !stream_mode && wave_end && reps != '0
		|=> rd_ptr == $past(cur.addr) && reps == $past(reps) - 1'b1)
		else $error("repeat did not restart waveform");

	COV_PLAY: cover property (@(posedge clk) disable iff (!resetn) $rose(sample_valid));
	COV_WRAP: cover property (@(posedge clk) disable iff (!resetn)
		play_fire && stream_mode && rd_ptr == '0 && level != '0);
	COV_LOOP: cover property (@(posedge clk) disable iff (!resetn)
		state == wpds_pkg::WPDS_S_FETCH && script[pc].op == wpds_pkg::WPDS_OP_ENDLOOP
		&& loop_cnt != '0);
endmodule

`default_nettype wire
